// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tlsir_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary
    localparam logic [7:0] REV = 8'h21; // arbitrary
    typedef struct packed {logic [7:0] p; logic w; logic [7:0] d; logic [7:0] e; logic [7:0] m;} tlsir_row_type;
    typedef struct packed {logic [7:0] rt; logic [7:0] lt; logic [4:0] f;} tlsir_trow_type;
    // bit 6 of status is masked: it may read either way
    localparam tlsir_row_type ROWS [14] = '{
        '{8'h33, 1'h0, 8'h00, 8'h80, 8'hBF}, '{8'h07, 1'h0, 8'h00, 8'h55, 8'hFF},
        '{8'h20, 1'h0, 8'h00, 8'h55, 8'hFF}, '{8'h19, 1'h0, 8'h00, 8'h6E, 8'hFF},
        '{8'h21, 1'h0, 8'h00, 8'h0A, 8'hFF}, '{8'h33, 1'h0, 8'h00, 8'h00, 8'hBF},
        '{8'h07, 1'h1, 8'h60, 8'h60, 8'hFF}, '{8'h19, 1'h1, 8'hFF, 8'hFF, 8'hFF},
        '{8'h20, 1'h1, 8'h7F, 8'h7F, 8'hFF}, '{8'h21, 1'h1, 8'hFF, 8'h1F, 8'hFF},
        '{8'h33, 1'h1, 8'hFF, 8'h00, 8'hBF}, '{8'hFE, 1'h1, 8'h00, MAKER, 8'hFF},
        '{8'hFF, 1'h1, 8'h00, REV, 8'hFF}, '{8'h50, 1'h1, 8'hAA, 8'h00, 8'hFF}};
    // flags {remote over, remote crit, local, over_n, crit_n}
    localparam tlsir_trow_type TROWS [5] = '{'{8'h61, 8'h00, 5'b11000}, '{8'h5F, 8'h80, 5'b11100},
        '{8'h59, 8'h7A, 5'b01100}, '{8'h58, 8'h79, 5'b00011}, '{8'h5F, 8'h7F, 5'b01010}};
    logic clk, srst, sda_o, sda_oe, scl, pull, ok, otn, crn, rof, rcf, llf;
    logic [7:0] rt, lt, adj, d, d2;
    wire sda = !((sda_oe && !sda_o) || pull); // pulled up when released
    int n_fail = 0;
    int checked = 0;
    tlsir_top #(.POWERUP_CNT(1000), .MAKER_CODE(MAKER), .DIE_REVISION_CODE(REV)) dut (.CLK(clk),
        .SRST(srst), .SMB_CLK_I(scl), .SMB_DAT_I(sda), .SMB_DAT_O(sda_o), .SMB_DAT_OE(sda_oe),
        .REMOTE_TEMP(rt), .LOCAL_TEMP(lt), .REMOTE_TEMP_ADJ(adj), .OVERTEMP_OUTPUT_N(otn),
        .CRITICAL_TEMP_OUTPUT_N(crn), .REMOTE_OVERTEMP_FLAG(rof), .REMOTE_CRITICAL_FLAG(rcf),
        .LOCAL_LIMIT_FLAG(llf));
    tlsir_host host (.scl(scl), .pull(pull), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic temps(input logic [7:0] r, input logic [7:0] l);
        @(negedge clk);
        rt = r;
        lt = l;
        repeat (4) @(negedge clk);
    endtask : temps
    // watchdog, about twice the expected run
    initial begin
        #500000;
        n_fail++;
        test_done();
    end
    initial begin
        srst = 1'b1;
        rt = 8'h00;
        lt = 8'h00;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].w) host.wr(SMB_SLAVE_ADDR, ROWS[i].p, ROWS[i].d, ok);
            host.rd(ROWS[i].p, d);
            chk(d & ROWS[i].m, ROWS[i].e);
        end
        $display("register table done");
        host.wr(SMB_SLAVE_ADDR ^ 7'h01, 8'h07, 8'h11, ok);
        chk({7'h0, ok}, 8'h00);
        host.rd(8'h07, d);
        chk(d, 8'h60);
        host.rd(8'h0D, d);
        chk(d, 8'h60);
        $display("wrong address done");
        host.wr(SMB_SLAVE_ADDR, 8'h21, 8'h05, ok);
        host.wr(SMB_SLAVE_ADDR, 8'h19, 8'h5E, ok);
        foreach (TROWS[i]) begin
            temps(TROWS[i].rt, TROWS[i].lt);
            chk({3'h0, rof, rcf, llf, otn, crn}, {3'h0, TROWS[i].f});
        end
        $display("limit flags done");
        host.wr(SMB_SLAVE_ADDR, 8'h11, 8'hFE, ok);
        host.rd(8'h11, d);
        chk(d, 8'hFE);
        temps(8'h10, 8'h00);
        chk(adj, 8'h0E);
        temps(8'h01, 8'h00);
        chk(adj, 8'h00);
        $display("offset done");
        host.rd2(8'hFE, d, d2);
        chk(d, MAKER);
        chk(d2, MAKER);
        $display("repeated read done");
        // mid-run reset with a hot sensor: flags drop and stay quiet until power-up ends
        temps(8'hFF, 8'hFF);
        chk({3'h0, rof, rcf, llf, otn, crn}, 8'h1C);
        srst = 1'b1;
        repeat (12) @(negedge clk);
        chk({3'h0, rof, rcf, llf, otn, crn}, 8'h03);
        chk(adj, 8'h00);
        srst = 1'b0;
        host.rd(8'h33, d);
        chk(d & 8'hBF, 8'h80);
        host.rd(8'h07, d);
        chk(d, 8'h55);
        chk({3'h0, rof, rcf, llf, otn, crn}, 8'h03);
        repeat (1000) @(negedge clk);
        chk({3'h0, rof, rcf, llf, otn, crn}, 8'h1C);
        chk(adj, 8'hFF);
        $display("reset done");
        test_done();
    end
endmodule : testbench

// File: tb/tlsir_host.sv
`timescale 1ns/1ps
module tlsir_host (
    // serial pins, pull high means pulling data low
    output logic scl,
    output logic pull,
    input wire logic sda
);
    import tlsir_pkg::*;
    logic ack_q;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // 200 ns bit period in equal halves; the slave answers about three cycles after the fall
    task automatic put_bit(input logic b);
        #40 pull = ~b;
        #60 scl = 1'b1;
        #100 scl = 1'b0;
    endtask : put_bit
    // sample late in the high phase
    task automatic get_bit(output logic b);
        #40 pull = 1'b0;
        #60 scl = 1'b1;
        #95 b = sda;
        #5 scl = 1'b0;
    endtask : get_bit
    task automatic put_byte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        ack_q = ~a;
    endtask : put_byte
    // start or repeated start; clock stands still outside frames
    task automatic start();
        #40 pull = 1'b0;
        #60 scl = 1'b1;
        #100 pull = 1'b1;
        #100 scl = 1'b0;
    endtask : start
    task automatic stop();
        #40 pull = 1'b1;
        #60 scl = 1'b1;
        #100 pull = 1'b0;
        #100;
    endtask : stop
    // diode model choice is never touched by this host
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        start();
        put_byte({a, 1'b0});
        ok = ack_q;
        if (ok) begin
            put_byte(p);
            put_byte(d);
        end
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        start();
        put_byte({SMB_SLAVE_ADDR, 1'b0});
        put_byte(p);
        start();
        put_byte({SMB_SLAVE_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask : rd
    // two-byte read: the master acknowledges the first byte, so the slave sends again
    task automatic rd2(input logic [7:0] p, output logic [7:0] d, output logic [7:0] e);
        start();
        put_byte({SMB_SLAVE_ADDR, 1'b0});
        put_byte(p);
        start();
        put_byte({SMB_SLAVE_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b0);
        for (int i = 7; i >= 0; i--) get_bit(e[i]);
        put_bit(1'b1);
        stop();
    endtask : rd2
endmodule : tlsir_host

// File: tb/tlsir_top_props.sv
`timescale 1ns/1ps
module tlsir_top_props #(
    parameter int POWERUP_CNT = 1000
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // serial pins
    input wire logic SMB_CLK_I,
    input wire logic SMB_DAT_I,
    input wire logic SMB_DAT_O,
    input wire logic SMB_DAT_OE,
    // temperatures and results
    input wire logic [7:0] REMOTE_TEMP,
    input wire logic [7:0] LOCAL_TEMP,
    input wire logic [7:0] REMOTE_TEMP_ADJ,
    input wire logic OVERTEMP_OUTPUT_N,
    input wire logic CRITICAL_TEMP_OUTPUT_N,
    input wire logic REMOTE_OVERTEMP_FLAG,
    input wire logic REMOTE_CRITICAL_FLAG,
    input wire logic LOCAL_LIMIT_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    logic [31:0] cnt_q;
    // cycles since reset release, saturating at the power-up length
    always_ff @(posedge CLK) begin
        if (SRST) cnt_q <= 32'h0;
        else if (cnt_q < 32'(POWERUP_CNT)) cnt_q <= cnt_q + 32'h1;
    end
    sequence s_release;
        $fell(SRST) ##1 !SRST;
    endsequence
    property p_odrain; SMB_DAT_O == 1'b0; endproperty
    property p_ot; OVERTEMP_OUTPUT_N == !(REMOTE_OVERTEMP_FLAG || LOCAL_LIMIT_FLAG); endproperty
    property p_crit; CRITICAL_TEMP_OUTPUT_N == !(REMOTE_CRITICAL_FLAG || LOCAL_LIMIT_FLAG); endproperty
    property p_frozen;
        (cnt_q < 32'(POWERUP_CNT)) |-> !(REMOTE_OVERTEMP_FLAG || REMOTE_CRITICAL_FLAG || LOCAL_LIMIT_FLAG);
    endproperty
    // offset still at zero until the host has had time to write it
    property p_adj0;
        (cnt_q >= 32'h2 && cnt_q < 32'(POWERUP_CNT)) |-> REMOTE_TEMP_ADJ == $past(REMOTE_TEMP);
    endproperty
    property p_rise_ro; $rose(REMOTE_OVERTEMP_FLAG) |-> $past(REMOTE_TEMP_ADJ) != 8'h00; endproperty
    property p_rise_lf; $rose(LOCAL_LIMIT_FLAG) |-> $past(LOCAL_TEMP) != 8'h00; endproperty
    property p_release; s_release |-> OVERTEMP_OUTPUT_N && CRITICAL_TEMP_OUTPUT_N && !SMB_DAT_OE; endproperty
    a_odrain: assert property (p_odrain) else $error("data output not low");
    a_ot: assert property (p_ot) else $error("overtemp output mismatch");
    a_crit: assert property (p_crit) else $error("critical output mismatch");
    a_frozen: assert property (p_frozen) else $error("flag during power-up");
    a_adj0: assert property (p_adj0) else $error("adjusted temp wrong");
    a_rise_ro: assert property (p_rise_ro) else $error("remote flag without heat");
    a_rise_lf: assert property (p_rise_lf) else $error("local flag without heat");
    a_release: assert property (p_release) else $error("outputs active after reset");
endmodule : tlsir_top_props
bind tlsir_top tlsir_top_props #(.POWERUP_CNT(POWERUP_CNT)) u_props (.CLK(CLK), .SRST(SRST),
    .SMB_CLK_I(SMB_CLK_I), .SMB_DAT_I(SMB_DAT_I), .SMB_DAT_O(SMB_DAT_O), .SMB_DAT_OE(SMB_DAT_OE),
    .REMOTE_TEMP(REMOTE_TEMP), .LOCAL_TEMP(LOCAL_TEMP), .REMOTE_TEMP_ADJ(REMOTE_TEMP_ADJ),
    .OVERTEMP_OUTPUT_N(OVERTEMP_OUTPUT_N), .CRITICAL_TEMP_OUTPUT_N(CRITICAL_TEMP_OUTPUT_N),
    .REMOTE_OVERTEMP_FLAG(REMOTE_OVERTEMP_FLAG), .REMOTE_CRITICAL_FLAG(REMOTE_CRITICAL_FLAG),
    .LOCAL_LIMIT_FLAG(LOCAL_LIMIT_FLAG));

// File: verilog/tlsir_pkg.sv
package tlsir_pkg;
    // register offsets
    localparam logic [7:0] OFS_REMOTE_OVERTEMP_LIMIT = 8'h07;
    localparam logic [7:0] OFS_REMOTE_OVERTEMP_ALIAS = 8'h0D;
    localparam logic [7:0] OFS_REMOTE_OFFSET = 8'h11;
    localparam logic [7:0] OFS_REMOTE_CRITICAL_LIMIT = 8'h19;
    localparam logic [7:0] OFS_LOCAL_SHARED_LIMIT = 8'h20;
    localparam logic [7:0] OFS_COMMON_HYSTERESIS = 8'h21;
    localparam logic [7:0] OFS_POWER_UP_STATUS = 8'h33;
    localparam logic [7:0] OFS_MAKER_CODE = 8'hFE;
    localparam logic [7:0] OFS_DIE_REVISION_CODE = 8'hFF;
    // values after reset
    localparam logic [7:0] RST_REMOTE_OVERTEMP_LIMIT = 8'h55;
    localparam logic [7:0] RST_LOCAL_SHARED_LIMIT = 8'h55;
    localparam logic [7:0] RST_REMOTE_CRITICAL_LIMIT = 8'h6E;
    localparam logic [4:0] RST_COMMON_HYSTERESIS = 5'h0A;
    localparam logic [7:0] RST_REMOTE_OFFSET = 8'h00;
    // field positions
    localparam int NOT_READY_BIT = 7;
    localparam int HYST_WIDTH = 5;
    // timing
    localparam longint CLK_FREQ_HZ = 40000000;
    localparam longint POWERUP_TIME_MS = 30;
    localparam int POWERUP_CYCLES = int'((POWERUP_TIME_MS * CLK_FREQ_HZ) / 1000);
    localparam int POWERUP_CNT_WIDTH = 21;
    // serial slave address, 7 bits
    localparam logic [6:0] SMB_SLAVE_ADDR = 7'h4C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [6:0] {
        TLSIR_IDLE = 7'h01,
        TLSIR_ADDR = 7'h02,
        TLSIR_ACK_ADDR = 7'h04,
        TLSIR_WDATA = 7'h08,
        TLSIR_ACK_W = 7'h10,
        TLSIR_RDATA = 7'h20,
        TLSIR_ACK_R = 7'h40
    } tlsir_smb_state_type;
endpackage : tlsir_pkg

// File: verilog/tlsir_smb.sv
`timescale 1ns/1ps
module tlsir_smb (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // register side
    output logic [7:0] ptr,
    output logic [7:0] wr_data,
    output logic wr_stb,
    input wire logic [7:0] rd_data
);
    import tlsir_pkg::*;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        tlsir_smb_state_type st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic ptr_seen;
        logic [7:0] ptr;
        logic [7:0] wr_data;
        logic wr_stb;
        logic drive;
    } tlsir_smb_type;

    tlsir_smb_type s_q, s_d;
    logic start, stop, rise, fall;

    // edge and bus-condition detection on the second and third sync stages only
    always_comb begin
        start = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
        stop = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
        rise = s_q.scl_s & ~s_q.scl_p;
        fall = ~s_q.scl_s & s_q.scl_p;
    end

    // byte engine: sample on clock rise, change the data line only after clock fall
    always_comb begin
        s_d = s_q;
        s_d.scl_m = scl_i;
        s_d.scl_s = s_q.scl_m;
        s_d.scl_p = s_q.scl_s;
        s_d.sda_m = sda_i;
        s_d.sda_s = s_q.sda_m;
        s_d.sda_p = s_q.sda_s;
        s_d.wr_stb = 1'b0;
        if (stop) begin
            s_d.st = TLSIR_IDLE;
            s_d.drive = 1'b0;
        end else if (start) begin
            // repeated start keeps the pointer, so write-pointer-then-read works
            s_d.st = TLSIR_ADDR;
            s_d.bitcnt = 4'h0;
            s_d.drive = 1'b0;
            s_d.ptr_seen = 1'b0;
        end else begin
            unique case (s_q.st)
                TLSIR_IDLE: begin
                    s_d.drive = 1'b0;
                end
                TLSIR_ADDR, TLSIR_WDATA: begin
                    if (rise && s_q.bitcnt != BITS_PER_BYTE) begin
                        s_d.shreg = {s_q.shreg[6:0], s_q.sda_s};
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (fall && s_q.bitcnt == BITS_PER_BYTE) begin
                        if (s_q.st == TLSIR_ADDR) begin
                            if (s_q.shreg[7:1] == SMB_SLAVE_ADDR) begin
                                s_d.drive = 1'b1;
                                s_d.rw = s_q.shreg[0];
                                s_d.st = TLSIR_ACK_ADDR;
                            end else begin
                                s_d.st = TLSIR_IDLE;
                            end
                        end else begin
                            s_d.drive = 1'b1;
                            s_d.st = TLSIR_ACK_W;
                            if (!s_q.ptr_seen) begin
                                s_d.ptr = s_q.shreg;
                                s_d.ptr_seen = 1'b1;
                            end else begin
                                s_d.wr_data = s_q.shreg;
                                s_d.wr_stb = 1'b1;
                            end
                        end
                    end
                end
                TLSIR_ACK_ADDR: begin
                    if (fall) begin
                        if (s_q.rw) begin
                            s_d.shreg = rd_data;
                            s_d.drive = ~rd_data[7];
                            s_d.bitcnt = 4'h1;
                            s_d.st = TLSIR_RDATA;
                        end else begin
                            s_d.drive = 1'b0;
                            s_d.bitcnt = 4'h0;
                            s_d.st = TLSIR_WDATA;
                        end
                    end
                end
                TLSIR_ACK_W: begin
                    if (fall) begin
                        s_d.drive = 1'b0;
                        s_d.bitcnt = 4'h0;
                        s_d.st = TLSIR_WDATA;
                    end
                end
                TLSIR_RDATA: begin
                    if (fall) begin
                        if (s_q.bitcnt == BITS_PER_BYTE) begin
                            s_d.drive = 1'b0; // release for the master's acknowledge
                            s_d.st = TLSIR_ACK_R;
                        end else begin
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.drive = ~s_q.shreg[6];
                            s_d.bitcnt = s_q.bitcnt + 4'h1;
                        end
                    end
                end
                TLSIR_ACK_R: begin
                    if (rise && s_q.sda_s) begin
                        s_d.st = TLSIR_IDLE; // not acknowledged: wait for stop
                    end else if (fall) begin
                        // no auto-increment: the same register is sent again
                        s_d.shreg = rd_data;
                        s_d.drive = ~rd_data[7];
                        s_d.bitcnt = 4'h1;
                        s_d.st = TLSIR_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                     st: TLSIR_IDLE, bitcnt: 4'h0, shreg: 8'h00, rw: 1'b0, ptr_seen: 1'b0,
                     ptr: 8'h00, wr_data: 8'h00, wr_stb: 1'b0, drive: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = 1'b0; // open drain: only ever pulls low
    assign sda_oe = s_q.drive;
    assign ptr = s_q.ptr;
    assign wr_data = s_q.wr_data;
    assign wr_stb = s_q.wr_stb;
endmodule : tlsir_smb

// File: verilog/tlsir_top.sv
// Operation
// [RULE1] Power-up status bit 7 reads one until the power-up delay ends.
// [RULE2] Power-up status bit 6 is don't-care; bits 5..0 always read zero.
// [RULE3] Remote over-temperature limit: read/write unsigned byte, reset 55h.
// [RULE4] Local shared limit serves over-temperature and critical, read/write, reset 55h.
// [RULE5] Remote critical limit: unsigned whole-degree byte, reset 6Eh.
// [RULE6] Hysteresis holds five bits, upper three read zero, reset 0Ah.
// [RULE7] Maker code register is read-only and always returns its fixed code.
// [RULE8] Revision code is read-only; its value steps by one per die revision.
// [RULE9] Host selects the beta-compensated model only for processor substrate transistors.
// [RULE10] Programmed remote offset is added to remote temperature results.
// [RULE11] Limit flags set above limit, clear below limit minus hysteresis.
`timescale 1ns/1ps
module tlsir_top #(
    parameter int POWERUP_CNT = tlsir_pkg::POWERUP_CYCLES,
    // arbitrary neutral identity values
    parameter logic [7:0] MAKER_CODE = 8'hC4,
    parameter logic [7:0] DIE_REVISION_CODE = 8'h5A
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // serial management pins
    input wire logic SMB_CLK_I,
    input wire logic SMB_DAT_I,
    output logic SMB_DAT_O,
    output logic SMB_DAT_OE,
    // measured temperatures from the conversion engine, whole degrees
    input wire logic [7:0] REMOTE_TEMP,
    input wire logic [7:0] LOCAL_TEMP,
    // results
    output logic [7:0] REMOTE_TEMP_ADJ,
    output logic OVERTEMP_OUTPUT_N,
    output logic CRITICAL_TEMP_OUTPUT_N,
    output logic REMOTE_OVERTEMP_FLAG,
    output logic REMOTE_CRITICAL_FLAG,
    output logic LOCAL_LIMIT_FLAG
);
    import tlsir_pkg::*;

    typedef struct packed {
        logic [7:0] rem_lim;
        logic [7:0] loc_lim;
        logic [7:0] rem_crit;
        logic [HYST_WIDTH-1:0] hyst;
        logic [7:0] offset;
        logic [POWERUP_CNT_WIDTH-1:0] pu_cnt;
        logic not_ready;
        logic [7:0] rem_adj;
        logic rem_os_f;
        logic rem_crit_f;
        logic loc_f;
    } tlsir_regs_type;

    tlsir_regs_type r_q, r_d;
    logic [7:0] ptr, wr_data, rd_data;
    logic wr_stb;
    logic [9:0] adj_sum;

    tlsir_smb u_smb (
        .clk(CLK),
        .srst(SRST),
        .scl_i(SMB_CLK_I),
        .sda_i(SMB_DAT_I),
        .sda_o(SMB_DAT_O),
        .sda_oe(SMB_DAT_OE),
        .ptr(ptr),
        .wr_data(wr_data),
        .wr_stb(wr_stb),
        .rd_data(rd_data)
    );

    // hysteretic compare; a limit below the hysteresis clamps the release point to zero
    function automatic logic hyst_cmp(input logic flag, input logic [7:0] temp, input logic [7:0] lim,
                                      input logic [HYST_WIDTH-1:0] hy);
        logic [8:0] rel;
        rel = {1'b0, lim} - {4'h0, hy};
        if (temp > lim) begin
            return 1'b1;
        end else if (!rel[8] && temp < rel[7:0]) begin
            return 1'b0;
        end
        return flag;
    endfunction : hyst_cmp

    // read multiplexer; unmapped pointers read as zero
    always_comb begin
        unique case (ptr)
            OFS_REMOTE_OVERTEMP_LIMIT, OFS_REMOTE_OVERTEMP_ALIAS: rd_data = r_q.rem_lim; // RULE3
            OFS_LOCAL_SHARED_LIMIT: rd_data = r_q.loc_lim; // RULE4
            OFS_REMOTE_CRITICAL_LIMIT: rd_data = r_q.rem_crit; // RULE5
            OFS_COMMON_HYSTERESIS: rd_data = {3'h0, r_q.hyst}; // RULE6
            OFS_REMOTE_OFFSET: rd_data = r_q.offset;
            OFS_POWER_UP_STATUS: rd_data = {r_q.not_ready, 7'h00}; // RULE1 RULE2
            OFS_MAKER_CODE: rd_data = MAKER_CODE; // RULE7
            OFS_DIE_REVISION_CODE: rd_data = DIE_REVISION_CODE; // RULE8
            default: rd_data = 8'h00;
        endcase
    end

    // signed offset applied with saturation, so a negative correction never wraps to hot
    always_comb begin
        adj_sum = {2'b00, REMOTE_TEMP} + {{2{r_q.offset[7]}}, r_q.offset}; // RULE10
    end

    // register writes, power-up timer and limit flags
    always_comb begin
        r_d = r_q;
        if (wr_stb) begin
            unique case (ptr)
                OFS_REMOTE_OVERTEMP_LIMIT, OFS_REMOTE_OVERTEMP_ALIAS: r_d.rem_lim = wr_data; // RULE3
                OFS_LOCAL_SHARED_LIMIT: r_d.loc_lim = wr_data; // RULE4
                OFS_REMOTE_CRITICAL_LIMIT: r_d.rem_crit = wr_data; // RULE5
                OFS_COMMON_HYSTERESIS: r_d.hyst = wr_data[HYST_WIDTH-1:0]; // RULE6
                OFS_REMOTE_OFFSET: r_d.offset = wr_data;
                default: ; // read-only or unmapped: ignored
            endcase
        end
        if (r_q.not_ready) begin
            if (r_q.pu_cnt >= POWERUP_CNT[POWERUP_CNT_WIDTH-1:0] - 1'b1) begin
                r_d.not_ready = 1'b0; // RULE1
            end else begin
                r_d.pu_cnt = r_q.pu_cnt + 1'b1;
            end
        end
        if (adj_sum[9]) begin
            r_d.rem_adj = 8'h00;
        end else if (adj_sum[8]) begin
            r_d.rem_adj = 8'hFF;
        end else begin
            r_d.rem_adj = adj_sum[7:0]; // RULE10
        end
        // flags stay quiet until the power-up sequence has finished
        if (!r_q.not_ready) begin
            r_d.rem_os_f = hyst_cmp(r_q.rem_os_f, r_q.rem_adj, r_q.rem_lim, r_q.hyst); // RULE11
            r_d.rem_crit_f = hyst_cmp(r_q.rem_crit_f, r_q.rem_adj, r_q.rem_crit, r_q.hyst); // RULE11
            r_d.loc_f = hyst_cmp(r_q.loc_f, LOCAL_TEMP, r_q.loc_lim, r_q.hyst); // RULE11 RULE4
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            r_q <= '{rem_lim: RST_REMOTE_OVERTEMP_LIMIT, loc_lim: RST_LOCAL_SHARED_LIMIT,
                     rem_crit: RST_REMOTE_CRITICAL_LIMIT, hyst: RST_COMMON_HYSTERESIS,
                     offset: RST_REMOTE_OFFSET, pu_cnt: '0, not_ready: 1'b1, rem_adj: 8'h00,
                     rem_os_f: 1'b0, rem_crit_f: 1'b0, loc_f: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // shared local limit drives both outputs
    assign OVERTEMP_OUTPUT_N = ~(r_q.rem_os_f | r_q.loc_f);
    assign CRITICAL_TEMP_OUTPUT_N = ~(r_q.rem_crit_f | r_q.loc_f);
    assign REMOTE_TEMP_ADJ = r_q.rem_adj;
    assign REMOTE_OVERTEMP_FLAG = r_q.rem_os_f;
    assign REMOTE_CRITICAL_FLAG = r_q.rem_crit_f;
    assign LOCAL_LIMIT_FLAG = r_q.loc_f;
endmodule : tlsir_top
